/* efc_pkg.sv */
package efc_pkg;
  // bus map
  localparam logic [15:0] EFC_ARR_BASE   = 16'hE000;  // start of 8K array window
  localparam logic [15:0] EFC_USR_LO_BIG = 16'hE000;
  localparam logic [15:0] EFC_USR_LO_SML = 16'hEE00;
  localparam logic [15:0] EFC_USR_HI     = 16'hFDFF;
  localparam logic [15:0] EFC_CTL_ADDR   = 16'hFE08;
  localparam logic [15:0] EFC_PROT_ADDR  = 16'hFF7E;
  localparam logic [15:0] EFC_VEC_LO     = 16'hFFDC;
  localparam logic [15:0] EFC_VEC_HI     = 16'hFFFF;
  // array shape
  localparam int          EFC_ARR_AW     = 13;
  localparam int          EFC_ARR_WORDS  = 8192;
  localparam int          EFC_USR_BIG_SZ = 7680;
  localparam int          EFC_VEC_BYTES  = 36;
  localparam int          EFC_PAGE_LSB   = 6;        // 64-byte page
  localparam int          EFC_ROW_LSB    = 5;        // 32-byte row
  localparam logic [7:0]  EFC_ERASED     = 8'hFF;
  localparam logic [7:0]  EFC_PROT_NONE  = 8'hFF;
  // control register fields
  localparam int          EFC_BIT_WSEL   = 0;
  localparam int          EFC_BIT_ERASE  = 1;
  localparam int          EFC_BIT_MASS   = 2;
  localparam int          EFC_BIT_PUMP   = 3;
  localparam logic [3:0]  EFC_CTL_RST    = 4'h0;
  localparam logic [7:0]  EFC_RD_NONE    = 8'h00;

  typedef enum logic [1:0] {EFC_IDLE, EFC_ERASING, EFC_DONE} efc_op_t;
endpackage : efc_pkg

/* efc_array.sv */
`timescale 1ns/1ps
module efc_array
  import efc_pkg::*;
#(
  parameter int AW    = EFC_ARR_AW,
  parameter int WORDS = EFC_ARR_WORDS
) (
  // clock
  input  wire logic          clk,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata,
  // write port: program ands, erase stores the erased pattern
  input  wire logic          we,
  input  wire logic          prog,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // protect boundary byte, always visible
  output logic      [7:0]    prot_byte
);
  logic [7:0] mem [WORDS];

  // nonvolatile cells leave the factory erased
  initial begin
    for (int i = 0; i < WORDS; i++) begin
      mem[i] = EFC_ERASED;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      // programming can only pull bits to 0
      mem[waddr] <= prog ? (mem[waddr] & wdata) : wdata;
    end
  end

  assign rdata     = mem[raddr];
  assign prot_byte = mem[EFC_PROT_ADDR[AW-1:0]];
endmodule : efc_array

/* efc_protect.sv */
`timescale 1ns/1ps
module efc_protect
  import efc_pkg::*;
(
  // boundary byte and address under test
  input  wire logic [7:0]  prot_byte,
  input  wire logic [15:0] addr,
  // result
  output logic             hit,
  output logic             any
);
  function automatic logic [15:0] prot_start(input logic [7:0] pb);
    return {2'b11, pb[7:0], 6'h00};
  endfunction : prot_start

  // all ones in the boundary byte means nothing is locked
  assign any = (prot_byte != EFC_PROT_NONE);
  assign hit = any && (addr >= prot_start(prot_byte));
endmodule : efc_protect

/* efc_ctrl.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module efc_ctrl
  import efc_pkg::*;
#(
  parameter bit LARGE = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // cpu bus
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // charge pump
  output logic             pump_on,
  output logic             hv_to_array,
  output logic             busy
);
  typedef struct packed {
    logic                  write_select;
    logic                  erase_sel;
    logic                  mass_sel;
    logic                  pump_drive_enable;
    logic                  prot_seen;
    logic                  armed;
    logic [15:0]           tgt;
    efc_op_t               op;
    logic [EFC_ARR_AW-1:0] cnt;
    logic [7:0]            rdata;
    logic                  busy;
  } efc_state_t;

  efc_state_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////////
  // decode
  logic [15:0] usr_lo;
  logic        in_usr, in_vec, in_prot, in_arr, in_ctl;
  logic [7:0]  arr_rdata, prot_byte, ctl_rd;
  logic        addr_prot, tgt_prot, prot_any;
  logic        arr_we, arr_prog;
  logic [EFC_ARR_AW-1:0] arr_waddr;
  logic [7:0]  arr_wdata;
  logic        sel_any, want_wsel, want_erase, row_hit;

  assign usr_lo  = LARGE ? EFC_USR_LO_BIG : EFC_USR_LO_SML;
  assign in_usr  = (addr >= usr_lo) && (addr <= EFC_USR_HI);
  assign in_vec  = (addr >= EFC_VEC_LO) && (addr <= EFC_VEC_HI);
  assign in_prot = (addr == EFC_PROT_ADDR);
  assign in_arr  = in_usr || in_vec || in_prot;
  assign in_ctl  = (addr == EFC_CTL_ADDR);
  assign ctl_rd  = {4'h0, s_q.pump_drive_enable, s_q.mass_sel, s_q.erase_sel,
                    s_q.write_select};
  assign sel_any = s_q.write_select || s_q.erase_sel;
  assign row_hit = (addr[15:EFC_ROW_LSB] == s_q.tgt[15:EFC_ROW_LSB]);

  ////////////////////////////////////////////////////////////////////////
  // array and protection
  efc_array u_arr (
    .clk       (clk),
    .raddr     (addr[EFC_ARR_AW-1:0]),
    .rdata     (arr_rdata),
    .we        (arr_we),
    .prog      (arr_prog),
    .waddr     (arr_waddr),
    .wdata     (arr_wdata),
    .prot_byte (prot_byte)
  );

  efc_protect u_bus_prot (
    .prot_byte (prot_byte),
    .addr      (addr),
    .hit       (addr_prot),
    .any       ()
  );

  efc_protect u_tgt_prot (
    .prot_byte (prot_byte),
    .addr      (s_q.tgt),
    .hit       (tgt_prot),
    .any       (prot_any)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d       = s_q;
    arr_we    = 1'b0;
    arr_prog  = 1'b0;
    arr_waddr = s_q.cnt;
    arr_wdata = EFC_ERASED;
    // read data stands only in the cycle after the strobe
    s_d.rdata = EFC_RD_NONE;
    if (rd) begin
      if (in_ctl) begin
        s_d.rdata = ctl_rd;
      end else if (in_arr) begin
        s_d.rdata = arr_rdata;
      end
      if (in_prot && sel_any) begin
        s_d.prot_seen = 1'b1;
      end
    end

    if (wr && in_ctl) begin
      want_wsel  = wdata[EFC_BIT_WSEL];
      want_erase = wdata[EFC_BIT_ERASE];
      // a write asking for both keeps the old pair, never both set
      if (!(want_wsel && want_erase)) begin
        // a new selection is not taken while high voltage is on
        if (!s_q.pump_drive_enable || !want_wsel) begin
          s_d.write_select = want_wsel;
        end
        if (!s_q.pump_drive_enable || !want_erase) begin
          s_d.erase_sel = want_erase;
        end
      end
      s_d.mass_sel = wdata[EFC_BIT_MASS];
      if (!wdata[EFC_BIT_PUMP]) begin
        s_d.pump_drive_enable = 1'b0;
      end else if (!s_q.pump_drive_enable && sel_any && s_q.prot_seen
                   && s_q.armed && s_q.op == EFC_IDLE) begin
        // mass erase covers protected bytes, so any lock refuses it
        if (!(s_q.erase_sel && s_q.mass_sel ? prot_any : tgt_prot)) begin
          s_d.pump_drive_enable = 1'b1;
        end
      end
    end else begin
      want_wsel  = 1'b0;
      want_erase = 1'b0;
    end

    // deselecting drops the sequence progress
    if (!s_d.write_select && !s_d.erase_sel) begin
      s_d.prot_seen = 1'b0;
      s_d.armed     = 1'b0;
    end

    case (s_q.op)
      EFC_IDLE: begin
        if (!s_q.pump_drive_enable) begin
          if (wr && in_arr && sel_any && s_q.prot_seen) begin
            s_d.armed = 1'b1;
            s_d.tgt   = addr;
          end
          if (s_d.pump_drive_enable && s_q.erase_sel) begin
            s_d.op  = EFC_ERASING;
            s_d.cnt = s_q.mass_sel ? '0 :
                      {s_q.tgt[EFC_ARR_AW-1:EFC_PAGE_LSB], 6'h00};
          end
        end else if (!s_q.write_select) begin
          s_d.op = EFC_DONE;
        end else if (wr && in_arr && row_hit && !addr_prot) begin
          arr_we    = 1'b1;
          arr_prog  = 1'b1;
          arr_waddr = addr[EFC_ARR_AW-1:0];
          arr_wdata = wdata;
        end
      end
      EFC_ERASING: begin
        if (!s_q.erase_sel || !s_q.pump_drive_enable) begin
          s_d.op = EFC_DONE;
        end else begin
          arr_we  = 1'b1;
          s_d.cnt = s_q.cnt + 1'b1;
          // page erase stops at the page end, mass erase at the array end
          // a page is two rows, so its end is the end of the second row
          if (s_q.mass_sel ? (&s_q.cnt) : (&s_q.cnt[EFC_PAGE_LSB-1:0])) begin
            s_d.op = EFC_DONE;
          end
        end
      end
      EFC_DONE: begin
        if (!s_q.pump_drive_enable) begin
          s_d.op    = EFC_IDLE;
          s_d.armed = 1'b0;
        end
      end
      default: s_d.op = EFC_IDLE;
    endcase
    s_d.busy = (s_d.op == EFC_ERASING) || s_d.pump_drive_enable;

    if (srst) begin
      s_d       = '0;
      s_d.op    = EFC_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rdata       = s_q.rdata;
  assign pump_on     = s_q.pump_drive_enable;
  assign hv_to_array = s_q.pump_drive_enable;
  assign busy        = s_q.busy;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence seq_ctl_read;
    rd && in_ctl;
  endsequence

  sequence seq_erase_start;
    (s_q.op == EFC_IDLE) ##1 (s_q.op == EFC_ERASING);
  endsequence

  chk_select_interlock: assert property (@(posedge clk) disable iff (srst)
    !(s_q.write_select && s_q.erase_sel))
    else $error("program and erase select both set");

  chk_reset_clears: assert property (@(posedge clk)
    srst |=> (ctl_rd == 8'h00) && !pump_on)
    else $error("control bits not cleared by reset");

  chk_ctl_readback: assert property (@(posedge clk) disable iff (srst)
    seq_ctl_read |=> (rdata == $past(ctl_rd)) && (rdata[7:4] == 4'h0))
    else $error("control register read data wrong");

  chk_pump_needs_seq: assert property (@(posedge clk) disable iff (srst)
    $rose(s_q.pump_drive_enable) |-> $past(sel_any && s_q.prot_seen && s_q.armed))
    else $error("pump enabled without full sequence");

  chk_pump_prot: assert property (@(posedge clk) disable iff (srst)
    $rose(s_q.pump_drive_enable) |-> !$past(tgt_prot))
    else $error("pump enabled on protected target");

  chk_erase_fills: assert property (@(posedge clk) disable iff (srst)
    seq_erase_start |-> arr_we && !arr_prog && (arr_wdata == EFC_ERASED))
    else $error("erase walk not writing erased pattern");

  chk_page_bound: assert property (@(posedge clk) disable iff (srst)
    (s_q.op == EFC_ERASING) && !s_q.mass_sel |->
      s_q.cnt[EFC_ARR_AW-1:EFC_PAGE_LSB] == s_q.tgt[EFC_ARR_AW-1:EFC_PAGE_LSB])
    else $error("page erase left its page");

  chk_row_bound: assert property (@(posedge clk) disable iff (srst)
    arr_we && arr_prog |-> arr_waddr[EFC_ARR_AW-1:EFC_ROW_LSB]
                           == s_q.tgt[EFC_ARR_AW-1:EFC_ROW_LSB])
    else $error("program write outside target row");

  chk_no_restart: assert property (@(posedge clk) disable iff (srst)
    (s_q.op == EFC_DONE) && s_q.pump_drive_enable |=> s_q.op != EFC_ERASING)
    else $error("operation restarted under high voltage");
endmodule : efc_ctrl

/* efc_cpu_model.sv */
`timescale 1ns/1ps
module efc_cpu_model
  import efc_pkg::*;
(
  // clock
  input  wire logic        clk,
  // bus towards the block
  output logic      [15:0] addr,
  output logic      [7:0]  wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [7:0]  rdata
);
  initial begin
    addr  = 16'h0000;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // released bus shows inverted values, so a stale address never decodes
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask : bus_rd

  // select, boundary read, then target write
  task automatic arm(input logic [7:0] ctl, input logic [15:0] tgt);
    logic [7:0] v;
    bus_wr(EFC_CTL_ADDR, ctl);
    bus_rd(EFC_PROT_ADDR, v);
    bus_wr(tgt, 8'hFF);
  endtask : arm
endmodule : efc_cpu_model

/* embedded_flash_control_test.sv */
`timescale 1ns/1ps
module embedded_flash_control_test
  import efc_pkg::*;
;
  typedef struct packed {
    logic        is_wr;
    logic [15:0] a;
    logic [7:0]  d;
  } efc_tb_row_t;

  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  rdata_sml;
  logic        pump_on;
  logic        hv_to_array;
  logic        busy;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;

  // reads carry expected data
  localparam efc_tb_row_t ROWS [16] = '{
    '{1'b0, 16'hFE08, 8'h00}, '{1'b0, 16'hFF7E, 8'hFF}, '{1'b0, 16'hE000, 8'hFF},
    '{1'b0, 16'hFDFF, 8'hFF}, '{1'b0, 16'hFFDC, 8'hFF}, '{1'b0, 16'hFFFF, 8'hFF},
    '{1'b0, 16'hFE09, 8'h00}, '{1'b0, 16'hDFFF, 8'h00},
    '{1'b1, 16'hFE08, 8'h04}, '{1'b0, 16'hFE08, 8'h04},
    '{1'b1, 16'hFE08, 8'h01}, '{1'b1, 16'hFE08, 8'h03}, '{1'b0, 16'hFE08, 8'h01},
    '{1'b1, 16'hFE08, 8'hF8}, '{1'b0, 16'hFE08, 8'h00}, '{1'b1, 16'hFE08, 8'h02}
  };

  always #5 clk = ~clk;

  efc_ctrl #(.LARGE(1'b1)) efc_ctrl_i (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pump_on(pump_on), .hv_to_array(hv_to_array), .busy(busy)
  );

  // small variant on the same bus, only its read data is watched
  efc_ctrl #(.LARGE(1'b0)) efc_ctrl_sml_i (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata_sml), .pump_on(), .hv_to_array(), .busy()
  );

  efc_cpu_model efc_cpu_model_i (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    efc_cpu_model_i.bus_rd(a, v);
    check($sformatf("read %h", a), v, exp);
  endtask : rd_chk

  // program one byte; a write to the other row of the page must be dropped
  task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic ok);
    efc_cpu_model_i.arm(8'h01, a);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h09);
    rd_chk(EFC_CTL_ADDR, ok ? 8'h09 : 8'h01);
    check("hv out", {7'h00, hv_to_array}, {7'h00, ok});
    efc_cpu_model_i.bus_wr(a, d);
    efc_cpu_model_i.bus_wr(a ^ 16'h0020, 8'h00);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h08);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h00);
  endtask : prog

  task automatic erase(input logic [15:0] a, input logic mass, input logic ok, input int n);
    efc_cpu_model_i.arm(mass ? 8'h06 : 8'h02, a);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, mass ? 8'h0E : 8'h0A);
    @(negedge clk);
    check("pump", {7'h00, pump_on}, {7'h00, ok});
    check("busy", {7'h00, busy}, {7'h00, ok});
    repeat (n) @(posedge clk);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h08);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h00);
    @(negedge clk);
    check("idle", {7'h00, busy}, 8'h00);
  endtask : erase

  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // whole run needs roughly 10k cycles, mostly the whole-array erase
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    check("pump rst", {6'h00, pump_on, hv_to_array}, 8'h00);
    check("rdata rst", rdata, 8'h00);
    for (int i = 0; i < 16; i++) begin
      if (ROWS[i].is_wr) efc_cpu_model_i.bus_wr(ROWS[i].a, ROWS[i].d);
      else rd_chk(ROWS[i].a, ROWS[i].d);
    end
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h00);
    // the small variant answers the same read in the same cycle, still standing here
    rd_chk(16'hEDFF, 8'hFF);
    check("small below", rdata_sml, 8'h00);
    rd_chk(16'hEE00, 8'hFF);
    check("small base", rdata_sml, 8'hFF);
    $display("done: map and control bits");
    prog(16'hE041, 8'hA5, 1'b1);
    rd_chk(16'hE061, 8'hFF);
    prog(16'hE041, 8'h0F, 1'b1);
    rd_chk(16'hE041, 8'h05);
    prog(16'hE07F, 8'h3C, 1'b1);
    prog(16'hE080, 8'h11, 1'b1);
    erase(16'hE041, 1'b0, 1'b1, 70);
    rd_chk(16'hE041, 8'hFF);
    rd_chk(16'hE07F, 8'hFF);
    rd_chk(16'hE080, 8'h11);
    $display("done: program and page erase");
    // pulling erase select with the pump still on aborts; reselect is refused
    efc_cpu_model_i.arm(8'h02, 16'hE0C0);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h0A);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h08);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h0A);
    rd_chk(EFC_CTL_ADDR, 8'h08);
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h00);
    erase(16'hE123, 1'b1, 1'b1, 8200);
    rd_chk(16'hE080, 8'hFF);
    $display("done: abort and whole-array erase");
    prog(EFC_PROT_ADDR, 8'hF7, 1'b1);
    rd_chk(EFC_PROT_ADDR, 8'hF7);
    // boundary F7 locks FDC0 up to FFFF, the page just below stays free
    prog(16'hFD80, 8'h5A, 1'b1);
    rd_chk(16'hFD80, 8'h5A);
    prog(16'hFDC0, 8'h00, 1'b0);
    rd_chk(16'hFDC0, 8'hFF);
    prog(16'hFFFE, 8'h00, 1'b0);
    rd_chk(16'hFFFE, 8'hFF);
    erase(16'hFDC0, 1'b0, 1'b0, 2);
    erase(16'hE000, 1'b1, 1'b0, 2);
    rd_chk(16'hFD80, 8'h5A);
    $display("done: protection");
    efc_cpu_model_i.bus_wr(EFC_CTL_ADDR, 8'h04);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_chk(EFC_CTL_ADDR, 8'h00);
    $display("done: second reset");
    wrap_up();
  end
endmodule : embedded_flash_control_test
